// file: core/fiwc_ctrl.sv
/*
  In-application flash write controller: configuration load after power-on,
  region permission checks for data-move and code reads, keyed write enables,
  byte program / EEPROM write with CPU stall and a selectable watchdog.
  Assumes the flash array returns read data in the same cycle as o_fl_rd and
  reports the end of a program or EEPROM write on i_prog_done.
*/
// Overview of operation
// (RL1) after power-on reset, copy last eight flash bytes into control registers; the code reads all eight but keeps only 3FFBh, 3FFDh and 3FFFh
// (RL2) default data region is 3000h-3FEFh large, 1000h-1FEFh small variant
// (RL3) software writes are single-byte programs, never preceded by a page erase
// (RL4) lowest 512 bytes: lock blocks all; unlocked allows code, data-move needs all-area
// (RL5) region 0200h-3EFFh: data-move only with all-area flag, code reads always
// (RL6) writing 65h to 97h sets all-area flag, any other value clears it
// (RL7) bit 0 of 97h reads the all-area flag, which resets to zero
// (RL8) region 3F00h-3FF7h is always open to data-move and code reads
// (RL9) 3FF8h-3FFEh data-move needs all-area flag; 3FFFh never data-move accessible
// (RL10) low config byte loads F6h, bandgap byte F5h; software writes then rule
// (RL11) data-move write to 0000h-3FFEh programs only when flash write enable set
// (RL12) during a program the CPU stalls while peripherals keep running
// (RL13) software services interrupts that went pending during the stall
// (RL14) flash reads complete without CPU wait cycles
// (RL15) C9h: 47h sets flash enable, E2h sets EEPROM enable, other clears both
// (RL16) C9h reads flash enable bit 7, timeout bit 6, EEPROM enable bit 5
// (RL17) timeout flag set on write timeout, cleared when its write enable clears
// (RL18) watchdog select: off, 0.9 ms, 3.6 ms, 7.2 ms; expiry flags and aborts
// (RL19) software keeps a boot region untouched while reprogramming
// (RL20) software clears all-area and write enables right after use
// (RL21) EEPROM writes stall and share the watchdog, gated by EEPROM enable
// (RL22) a rejected write neither stalls nor starts a program or watchdog
// (RL23) watchdog restarts at every accepted program and stops on normal completion
module fiwc_ctrl
  import fiwc_pkg::*;
#(
  parameter bit LARGE_MEM = 1'b1,
  parameter int TMO_SHORT = TMO_SHORT_CYC,
  parameter int TMO_MID = TMO_MID_CYC,
  parameter int TMO_LONG = TMO_LONG_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic i_mem_code,
  input wire logic [15:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  output logic o_mem_rvalid,
  output logic [7:0] o_mem_rdata,
  output logic o_mem_denied,
  output logic o_mem_in_default,
  output logic o_cpu_stall,
  output logic [15:0] o_fl_addr,
  output logic o_fl_rd,
  output logic o_fl_prog,
  output logic o_ee_prog,
  output logic [7:0] o_prog_wdata,
  output logic o_prog_abort,
  input wire logic [7:0] i_fl_rdata,
  input wire logic i_prog_done,
  output logic [7:0] o_cfg_high,
  output logic [7:0] o_cfg_low,
  output logic [7:0] o_cfg_bandgap,
  output logic [7:0] o_auxiliary_control_two,
  output logic o_soft_reset_req
);

  typedef struct packed {
    fiwc_state_t st;
    logic [2:0] ld_idx;
    logic ld_done;
    logic all_area;
    logic fl_we;
    logic ee_we;
    logic tmo;
    logic [7:0] auxiliary_control_two;
    logic [7:0] cfg_high;
    logic [7:0] cfg_low;
    logic [7:0] cfg_bg;
    logic [WD_W-1:0] wd_cnt;
    logic stall;
    logic [15:0] fl_addr;
    logic fl_rd;
    logic fl_prog;
    logic ee_prog;
    logic [7:0] wdata;
    logic abort;
    logic [7:0] sfr_rdata;
    logic rvalid;
    logic [7:0] rdata;
    logic denied;
    logic in_default;
    logic soft_rst;
  } fiwc_regs_t;

  fiwc_regs_t cur_ff;
  fiwc_regs_t nxt_cur;

  // data-move permission per region
  function automatic logic movx_ok(input logic [15:0] a, input logic lock, input logic all);
    if (a <= LOCK_REGION_END) begin
      movx_ok = !lock && all; // RL4
    end else if (a <= ALL_REGION_END) begin
      movx_ok = all; // RL5
    end else if (a <= FREE_REGION_END) begin
      movx_ok = 1'b1; // RL8
    end else if (a < CFG_WORD_HIGH_ADDR) begin
      movx_ok = all; // RL9
    end else begin
      movx_ok = 1'b0; // RL9
    end
  endfunction

  // code-read permission: only the lowest region can refuse
  function automatic logic code_ok(input logic [15:0] a, input logic lock);
    code_ok = (a > LOCK_REGION_END) || !lock; // RL4
  endfunction

  function automatic logic in_default(input logic [15:0] a);
    if (LARGE_MEM) begin
      in_default = (a >= DEF_LARGE_START) && (a <= DEF_LARGE_END); // RL2
    end else begin
      in_default = (a >= DEF_SMALL_START) && (a <= DEF_SMALL_END); // RL2
    end
  endfunction

  logic [WD_W-1:0] wd_limit;
  logic lock;
  logic is_flash;
  logic is_eeprom;
  logic [1:0] wd_sel;

  assign wd_sel = cur_ff.auxiliary_control_two[AUXILIARY_CONTROL_TWO_SEL_LSB +: 2];
  assign lock = cur_ff.cfg_high[CFGH_LOCK_BIT];
  assign is_flash = i_mem_addr < CFG_WORD_HIGH_ADDR || i_mem_addr == CFG_WORD_HIGH_ADDR;
  assign is_eeprom = (i_mem_addr >= EEPROM_START) && (i_mem_addr <= EEPROM_END)
                     && !i_mem_addr[0];

  always_comb begin
    case (wd_sel)
      2'b01: wd_limit = WD_W'(TMO_SHORT); // RL18
      2'b10: wd_limit = WD_W'(TMO_MID); // RL18
      2'b11: wd_limit = WD_W'(TMO_LONG); // RL18
      default: wd_limit = '0;
    endcase
  end

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.fl_rd = 1'b0;
    nxt_cur.fl_prog = 1'b0;
    nxt_cur.ee_prog = 1'b0;
    nxt_cur.abort = 1'b0;
    nxt_cur.rvalid = 1'b0;
    nxt_cur.denied = 1'b0;
    nxt_cur.soft_rst = 1'b0;

    // register reads, one cycle behind the strobe
    nxt_cur.sfr_rdata = 8'h00;
    if (i_sfr_rd) begin
      case (i_sfr_addr)
        SFR_SW_COMMAND: nxt_cur.sfr_rdata = {7'h00, cur_ff.all_area}; // RL7
        SFR_WRITE_ENABLE_KEYS: begin
          nxt_cur.sfr_rdata[WEK_FLASH_BIT] = cur_ff.fl_we; // RL16
          nxt_cur.sfr_rdata[WEK_TIMEOUT_BIT] = cur_ff.tmo; // RL16
          nxt_cur.sfr_rdata[WEK_EEPROM_BIT] = cur_ff.ee_we; // RL16
        end
        SFR_BANDGAP_CFG: nxt_cur.sfr_rdata = cur_ff.cfg_bg;
        SFR_CFG_LOW: nxt_cur.sfr_rdata = cur_ff.cfg_low;
        SFR_AUX_CONTROL_TWO: nxt_cur.sfr_rdata = cur_ff.auxiliary_control_two;
        default: nxt_cur.sfr_rdata = 8'h00;
      endcase
    end

    // register writes; the timeout set below wins over a clear here
    if (i_sfr_wr) begin
      case (i_sfr_addr)
        SFR_SW_COMMAND: begin
          nxt_cur.all_area = (i_sfr_wdata == KEY_ALL_AREA); // RL6
          nxt_cur.soft_rst = (i_sfr_wdata == KEY_SOFT_RESET);
        end
        SFR_WRITE_ENABLE_KEYS: begin
          if (i_sfr_wdata == KEY_FLASH_WE) begin
            nxt_cur.fl_we = 1'b1; // RL15
          end else if (i_sfr_wdata == KEY_EEPROM_WE) begin
            nxt_cur.ee_we = 1'b1; // RL15
          end else begin
            nxt_cur.fl_we = 1'b0; // RL15
            nxt_cur.ee_we = 1'b0; // RL15
            nxt_cur.tmo = 1'b0; // RL17
          end
        end
        SFR_BANDGAP_CFG: nxt_cur.cfg_bg = i_sfr_wdata; // RL10
        SFR_CFG_LOW: nxt_cur.cfg_low = i_sfr_wdata; // RL10
        SFR_AUX_CONTROL_TWO: nxt_cur.auxiliary_control_two = i_sfr_wdata & AUXILIARY_CONTROL_TWO_WRITE_MASK;
        default: ;
      endcase
    end

    // flash data is taken in the same cycle as the read strobe: no wait states
    if (cur_ff.fl_rd && cur_ff.st == FIWC_LOAD) begin
      case (cur_ff.fl_addr)
        CFG_BANDGAP_ADDR: nxt_cur.cfg_bg = i_fl_rdata; // RL10
        CFG_LOW_ADDR: nxt_cur.cfg_low = i_fl_rdata; // RL10
        CFG_WORD_HIGH_ADDR: nxt_cur.cfg_high = i_fl_rdata; // RL1
        default: ;
      endcase
    end else if (cur_ff.fl_rd) begin
      nxt_cur.rvalid = 1'b1; // RL14
      nxt_cur.rdata = i_fl_rdata; // RL14
    end

    case (cur_ff.st)
      FIWC_LOAD: begin
        // CPU held off until the whole configuration word is in
        nxt_cur.stall = 1'b1; // RL1
        if (!cur_ff.ld_done) begin
          nxt_cur.fl_rd = 1'b1; // RL1
          nxt_cur.fl_addr = CFG_REGION_START | {13'h0000, cur_ff.ld_idx}; // RL1
          nxt_cur.ld_idx = cur_ff.ld_idx + 3'd1;
          nxt_cur.ld_done = (cur_ff.ld_idx == 3'd7);
        end else if (cur_ff.fl_rd && cur_ff.fl_addr == CFG_WORD_HIGH_ADDR) begin
          nxt_cur.st = FIWC_IDLE;
          nxt_cur.stall = 1'b0;
        end
      end
      FIWC_IDLE: begin
        nxt_cur.stall = 1'b0;
        if (i_mem_wr) begin
          nxt_cur.in_default = in_default(i_mem_addr);
          if (is_flash && i_mem_addr != CFG_WORD_HIGH_ADDR
              && movx_ok(i_mem_addr, lock, cur_ff.all_area) && cur_ff.fl_we) begin
            // single byte program, no erase step exists
            nxt_cur.fl_prog = 1'b1; // RL3 RL11
            nxt_cur.fl_addr = i_mem_addr;
            nxt_cur.wdata = i_mem_wdata;
            nxt_cur.stall = 1'b1; // RL12
            nxt_cur.wd_cnt = '0; // RL23
            nxt_cur.st = FIWC_PROG;
          end else if (is_eeprom && cur_ff.ee_we) begin
            nxt_cur.ee_prog = 1'b1; // RL21
            nxt_cur.fl_addr = i_mem_addr;
            nxt_cur.wdata = i_mem_wdata;
            nxt_cur.stall = 1'b1; // RL21
            nxt_cur.wd_cnt = '0; // RL23
            nxt_cur.st = FIWC_PROG;
          end else begin
            // dropped: no stall, no program, watchdog untouched
            nxt_cur.denied = 1'b1; // RL22
          end
        end else if (i_mem_rd && is_flash) begin
          nxt_cur.in_default = in_default(i_mem_addr);
          if (i_mem_code ? code_ok(i_mem_addr, lock)
                         : movx_ok(i_mem_addr, lock, cur_ff.all_area)) begin
            nxt_cur.fl_rd = 1'b1; // RL14
            nxt_cur.fl_addr = i_mem_addr;
          end else begin
            nxt_cur.rvalid = 1'b1;
            nxt_cur.rdata = 8'h00;
            nxt_cur.denied = 1'b1;
          end
        end
      end
      FIWC_PROG: begin
        // peripherals are outside and run on; only the CPU waits
        nxt_cur.stall = 1'b1; // RL12
        nxt_cur.wd_cnt = cur_ff.wd_cnt + WD_W'(1); // RL23
        if (i_prog_done) begin
          nxt_cur.st = FIWC_IDLE; // RL23
          nxt_cur.stall = 1'b0; // RL12
        end else if (wd_sel != 2'b00 && cur_ff.wd_cnt == wd_limit - WD_W'(1)) begin
          nxt_cur.tmo = 1'b1; // RL17 RL18
          nxt_cur.abort = 1'b1; // RL18
          nxt_cur.st = FIWC_IDLE; // RL18
          nxt_cur.stall = 1'b0;
        end
      end
      default: nxt_cur.st = FIWC_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cur_ff <= '0;
      cur_ff.st <= FIWC_LOAD; // RL1
      cur_ff.auxiliary_control_two <= AUXILIARY_CONTROL_TWO_RESET;
      cur_ff.stall <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign o_sfr_rdata = cur_ff.sfr_rdata;
  assign o_mem_rvalid = cur_ff.rvalid;
  assign o_mem_rdata = cur_ff.rdata;
  assign o_mem_denied = cur_ff.denied;
  assign o_mem_in_default = cur_ff.in_default;
  assign o_cpu_stall = cur_ff.stall;
  assign o_fl_addr = cur_ff.fl_addr;
  assign o_fl_rd = cur_ff.fl_rd;
  assign o_fl_prog = cur_ff.fl_prog;
  assign o_ee_prog = cur_ff.ee_prog;
  assign o_prog_wdata = cur_ff.wdata;
  assign o_prog_abort = cur_ff.abort;
  assign o_cfg_high = cur_ff.cfg_high;
  assign o_cfg_low = cur_ff.cfg_low;
  assign o_cfg_bandgap = cur_ff.cfg_bg;
  assign o_auxiliary_control_two = cur_ff.auxiliary_control_two;
  assign o_soft_reset_req = cur_ff.soft_rst;

endmodule

// file: core/fiwc_pkg.sv
/*
  Constants for the in-application flash write controller: special register
  addresses, write keys, flash region bounds, reset values and watchdog times.
  Assumes a 100 MHz system clock and a 16-bit program address space.
*/
package fiwc_pkg;
  // special register addresses
  localparam logic [7:0] SFR_SW_COMMAND = 8'h97;
  localparam logic [7:0] SFR_WRITE_ENABLE_KEYS = 8'hC9;
  localparam logic [7:0] SFR_BANDGAP_CFG = 8'hF5;
  localparam logic [7:0] SFR_CFG_LOW = 8'hF6;
  localparam logic [7:0] SFR_AUX_CONTROL_TWO = 8'hF7;

  // write keys
  localparam logic [7:0] KEY_ALL_AREA = 8'h65;
  localparam logic [7:0] KEY_SOFT_RESET = 8'h56;
  localparam logic [7:0] KEY_FLASH_WE = 8'h47;
  localparam logic [7:0] KEY_EEPROM_WE = 8'hE2;

  // field positions
  localparam int WEK_FLASH_BIT = 7;
  localparam int WEK_TIMEOUT_BIT = 6;
  localparam int WEK_EEPROM_BIT = 5;
  localparam int AUXILIARY_CONTROL_TWO_SEL_LSB = 1;
  localparam int CFGH_LOCK_BIT = 1;
  localparam logic [7:0] AUXILIARY_CONTROL_TWO_WRITE_MASK = 8'hF7;
  localparam logic [7:0] AUXILIARY_CONTROL_TWO_RESET = 8'h06;

  // flash regions
  localparam logic [15:0] LOCK_REGION_END = 16'h01FF;
  localparam logic [15:0] ALL_REGION_END = 16'h3EFF;
  localparam logic [15:0] FREE_REGION_END = 16'h3FF7;
  localparam logic [15:0] CFG_REGION_START = 16'h3FF8;
  localparam logic [15:0] CFG_WORD_HIGH_ADDR = 16'h3FFF;
  localparam logic [15:0] CFG_BANDGAP_ADDR = 16'h3FFB;
  localparam logic [15:0] CFG_LOW_ADDR = 16'h3FFD;
  localparam logic [15:0] DEF_LARGE_START = 16'h3000;
  localparam logic [15:0] DEF_LARGE_END = 16'h3FEF;
  localparam logic [15:0] DEF_SMALL_START = 16'h1000;
  localparam logic [15:0] DEF_SMALL_END = 16'h1FEF;
  localparam logic [15:0] EEPROM_START = 16'hEE00;
  localparam logic [15:0] EEPROM_END = 16'hEEFE;

  // watchdog times
  localparam int CLK_PERIOD_NS = 10;
  localparam int TMO_SHORT_NS = 900_000;
  localparam int TMO_MID_NS = 3_600_000;
  localparam int TMO_LONG_NS = 7_200_000;
  localparam int TMO_SHORT_CYC = TMO_SHORT_NS / CLK_PERIOD_NS;
  localparam int TMO_MID_CYC = TMO_MID_NS / CLK_PERIOD_NS;
  localparam int TMO_LONG_CYC = TMO_LONG_NS / CLK_PERIOD_NS;
  localparam int WD_W = 20;

  typedef enum logic [1:0] {
    FIWC_LOAD,
    FIWC_IDLE,
    FIWC_PROG
  } fiwc_state_t;
endpackage

// file: dv/fiwc_flash_model.sv
/* Behavioural flash array on the far side of the write controller.
   Assumes one-cycle read and program strobes from the controller. */
module fiwc_flash_model #(
  parameter int PROG_CYC = 12
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_hang,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_fl_prog,
  input wire logic i_ee_prog,
  input wire logic i_abort,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_done
);
  logic [7:0] mem [16384];
  logic [7:0] last, pd;
  logic [13:0] a_q, pa;
  logic rd_q, busy, is_fl;
  int cnt;
  initial begin
    for (int i = 0; i < 16384; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
    mem[14'h3FFB] = 8'h5A;
    mem[14'h3FFD] = 8'hC3;
    mem[14'h3FFF] = 8'h02;
    {rd_q, busy, o_done, last} = 11'h000;
  end
  // data only around a read, else a moving pattern so stale bytes never match
  assign o_rdata = i_rd ? mem[i_addr[13:0]] : rd_q ? mem[a_q] : ~last;
  always @(posedge i_ref_clk) begin
    o_done <= 1'b0;
    rd_q <= i_rd;
    a_q <= i_addr[13:0];
    last <= o_rdata;
    if (i_sys_rst || i_abort) begin
      busy <= 1'b0;
    end else if (i_fl_prog || i_ee_prog) begin
      busy <= 1'b1;
      cnt <= 1;
      is_fl <= i_fl_prog;
      pa <= i_addr[13:0];
      pd <= i_wdata;
    end else if (busy && !i_hang) begin
      cnt <= cnt + 1;
      if (cnt == PROG_CYC) begin
        busy <= 1'b0;
        o_done <= 1'b1;
        if (is_fl) mem[pa] <= pd;
      end
    end
  end
endmodule

// file: dv/fiwc_ctrl_monitor.sv
/* Port checker for fiwc_ctrl, bound to every instance.
   Assumes one clock and a synchronous active-high reset. */
module fiwc_ctrl_monitor #(
  parameter int TMO_SHORT = 20,
  parameter int TMO_MID = 40,
  parameter int TMO_LONG = 80
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic i_mem_rd,
  input wire logic [15:0] i_mem_addr,
  input wire logic o_mem_rvalid,
  input wire logic o_mem_denied,
  input wire logic o_cpu_stall,
  input wire logic [15:0] o_fl_addr,
  input wire logic o_fl_rd,
  input wire logic o_fl_prog,
  input wire logic o_ee_prog,
  input wire logic o_prog_abort,
  input wire logic i_prog_done,
  input wire logic [7:0] o_auxiliary_control_two
);
  logic [15:0] wd_cnt_ff;
  int lim;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // cycles since the last program start, saturating
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wd_cnt_ff <= 16'h0000;
    end else if (o_fl_prog || o_ee_prog) begin
      wd_cnt_ff <= 16'h0001;
    end else if (wd_cnt_ff != 16'hFFFF) begin
      wd_cnt_ff <= wd_cnt_ff + 16'h0001;
    end
  end
  always_comb begin
    case (o_auxiliary_control_two[2:1])
      2'h1: lim = TMO_SHORT;
      2'h2: lim = TMO_MID;
      default: lim = TMO_LONG;
    endcase
  end
  a_reset_load: assert property ($fell(i_sys_rst) |-> o_cpu_stall [*8] ##[1:4] !o_cpu_stall)
    else $error("config load stall wrong");
  a_read_follows: assert property (i_mem_rd && !o_cpu_stall && i_mem_addr <= 16'h3FFF |=>
    (o_fl_rd && o_fl_addr == $past(i_mem_addr)) || o_mem_denied) else $error("read not issued");
  a_no_wait: assert property (o_fl_rd && !o_cpu_stall |=> o_mem_rvalid)
    else $error("read data late");
  a_denied_quiet: assert property (o_mem_denied |-> !o_cpu_stall && !o_fl_prog && !o_ee_prog)
    else $error("refused write started work");
  a_prog_stalls: assert property (o_fl_prog || o_ee_prog |-> o_cpu_stall)
    else $error("program without stall");
  a_done_release: assert property (i_prog_done && o_cpu_stall |=> !o_cpu_stall)
    else $error("stall held after done");
  a_abort_time: assert property (o_prog_abort |-> o_auxiliary_control_two[2:1] != 2'h0 && int'(wd_cnt_ff) == lim)
    else $error("abort at wrong time");
  a_allarea_key: assert property ((i_sfr_wr && i_sfr_addr == 8'h97) ##2
    (i_sfr_rd && i_sfr_addr == 8'h97) |=> o_sfr_rdata == {7'h00, $past(i_sfr_wdata, 3) == 8'h65})
    else $error("all-area flag readback wrong");
  c_abort: cover property (o_prog_abort);
  c_eeprom: cover property (o_ee_prog);
  c_denied: cover property (o_mem_denied);
endmodule

bind fiwc_ctrl fiwc_ctrl_monitor #(.TMO_SHORT(TMO_SHORT), .TMO_MID(TMO_MID),
  .TMO_LONG(TMO_LONG)) u_mon (.i_ref_clk, .i_sys_rst, .i_sfr_wr, .i_sfr_rd, .i_sfr_addr,
  .i_sfr_wdata, .o_sfr_rdata, .i_mem_rd, .i_mem_addr, .o_mem_rvalid, .o_mem_denied,
  .o_cpu_stall, .o_fl_addr, .o_fl_rd, .o_fl_prog, .o_ee_prog, .o_prog_abort, .i_prog_done,
  .o_auxiliary_control_two);

// file: dv/fiwc_ctrl_tb.sv
/* Testbench for fiwc_ctrl acting as the CPU, flash model on the far side.
   Assumes short watchdog counts through the design parameters. */
module fiwc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM [4] = '{0, 20, 40, 80};
  // flags nibble: all-area, code read, refused; then address and data
  localparam logic [31:0] T1 [12] = '{32'h0301_0000, 32'h0501_0000, 32'h0210_0010,
    32'h0110_0000, 32'h0410_0010, 32'h003F_003F, 32'h003F_F7C8, 32'h013F_F800,
    32'h043F_FB5A, 32'h053F_FF00, 32'h023F_FF02, 32'h013E_FF00};
  localparam logic [31:0] T2 [3] = '{32'h0201_0001, 32'h0101_0000, 32'h0401_FFFE};
  logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, hang = 1'b0;
  logic i_mem_rd = 1'b0, i_mem_wr = 1'b0, i_mem_code = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_mem_wdata = 8'h00;
  logic [15:0] i_mem_addr = 16'h0000;
  logic [7:0] o_sfr_rdata, o_mem_rdata, o_prog_wdata, i_fl_rdata, o_cfg_high, o_cfg_low;
  logic [7:0] o_cfg_bandgap, o_auxiliary_control_two;
  logic [15:0] o_fl_addr;
  logic o_mem_rvalid, o_mem_denied, o_mem_in_default, o_cpu_stall, o_fl_rd, o_fl_prog;
  logic o_ee_prog, o_prog_abort, i_prog_done, soft_req;
  logic soft_seen = 1'b0;
  int bad_count = 0, checks_done = 0;
  fiwc_ctrl #(.TMO_SHORT(LIM[1]), .TMO_MID(LIM[2]), .TMO_LONG(LIM[3])) i_dut (
    .i_ref_clk, .i_sys_rst, .i_sfr_wr, .i_sfr_rd, .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata,
    .i_mem_rd, .i_mem_wr, .i_mem_code, .i_mem_addr, .i_mem_wdata, .o_mem_rvalid,
    .o_mem_rdata, .o_mem_denied, .o_mem_in_default, .o_cpu_stall, .o_fl_addr, .o_fl_rd,
    .o_fl_prog, .o_ee_prog, .o_prog_wdata, .o_prog_abort, .i_fl_rdata, .i_prog_done,
    .o_cfg_high, .o_cfg_low, .o_cfg_bandgap, .o_auxiliary_control_two, .o_soft_reset_req(soft_req));
  // the request is a one-cycle pulse inside sfr_wr, so keep it sticky
  always @(posedge i_ref_clk) begin
    if (soft_req) soft_seen <= 1'b1;
  end
  fiwc_flash_model i_flash (.i_ref_clk, .i_sys_rst, .i_hang(hang), .i_addr(o_fl_addr),
    .i_rd(o_fl_rd), .i_fl_prog(o_fl_prog), .i_ee_prog(o_ee_prog), .i_abort(o_prog_abort),
    .i_wdata(o_prog_wdata), .o_rdata(i_fl_rdata), .o_done(i_prog_done));
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    {i_sfr_wr, i_sfr_addr, i_sfr_wdata} = {1'b1, a, d};
    @(negedge i_ref_clk);
    i_sfr_wr = 1'b0;
    @(negedge i_ref_clk);
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
    {i_sfr_rd, i_sfr_addr} = {1'b1, a};
    @(negedge i_ref_clk);
    i_sfr_rd = 1'b0;
    chk(o_sfr_rdata, e);
    @(negedge i_ref_clk);
  endtask
  task automatic mem_rd(input logic [31:0] t);
    sfr_wr(8'h97, t[26] ? 8'h65 : 8'h64);
    {i_mem_rd, i_mem_code, i_mem_addr} = {1'b1, t[25], t[23:8]};
    @(negedge i_ref_clk);
    i_mem_rd = 1'b0;
    for (int n = 0; n < 4 && !(o_mem_rvalid || o_mem_denied); n++) @(negedge i_ref_clk);
    chk(o_mem_denied, t[24]);
    chk(o_mem_rdata, t[7:0]);
    chk(o_mem_in_default, t[23:8] >= 16'h3000 && t[23:8] <= 16'h3FEF);
    @(negedge i_ref_clk);
  endtask
  task automatic mem_wr(input logic [15:0] a, input logic go, input int lim);
    int ab;
    {i_mem_wr, i_mem_addr, i_mem_wdata} = {1'b1, a, 8'hA5};
    @(negedge i_ref_clk);
    i_mem_wr = 1'b0;
    ab = 0;
    chk(o_fl_prog | o_ee_prog, go);
    chk(o_mem_denied, !go);
    chk(o_cpu_stall, go);
    for (int n = 0; n < 2000 && o_cpu_stall; n++) begin
      @(negedge i_ref_clk);
      if (o_prog_abort) ab = n + 1;
    end
    chk(16'(ab), 16'(lim));
    chk(o_cpu_stall, 1'b0);
  endtask
  task automatic do_reset();
    i_sys_rst = 1'b1;
    repeat (8) @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    for (int n = 0; n < 20 && o_cpu_stall !== 1'b0; n++) @(negedge i_ref_clk);
    chk(o_cpu_stall, 1'b0);
  endtask
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    do_reset();
    chk(o_cfg_high, 8'h02);
    chk(o_cfg_low, 8'hC3);
    chk(o_cfg_bandgap, 8'h5A);
    sfr_rd(8'hF7, 8'h06);
    sfr_rd(8'hC9, 8'h00);
    sfr_rd(8'h97, 8'h00);
    sfr_wr(8'hF6, 8'h11);
    sfr_rd(8'hF6, 8'h11);
    sfr_wr(8'h97, 8'h65);
    sfr_rd(8'h97, 8'h01);
    $display("test registers done");
    foreach (T1[i]) mem_rd(T1[i]);
    $display("test permissions done");
    sfr_wr(8'hC9, 8'h47);
    sfr_rd(8'hC9, 8'h80);
    sfr_wr(8'hC9, 8'hE2);
    sfr_rd(8'hC9, 8'hA0);
    sfr_wr(8'hC9, 8'h00);
    sfr_rd(8'hC9, 8'h00);
    mem_wr(16'h3F00, 1'b0, 0);
    sfr_wr(8'hC9, 8'h47);
    mem_wr(16'h1000, 1'b0, 0);
    mem_wr(16'h3F00, 1'b1, 0);
    mem_rd(32'h023F_00A5);
    hang = 1'b1;
    for (int s = 1; s < 4; s++) begin
      sfr_wr(8'hF7, {5'h00, 2'(s), 1'b0});
      sfr_wr(8'hC9, 8'h47);
      mem_wr(16'h3F10, 1'b1, LIM[s]);
      sfr_rd(8'hC9, 8'hC0);
      sfr_wr(8'hC9, 8'h00);
      sfr_rd(8'hC9, 8'h00);
    end
    hang = 1'b0;
    sfr_wr(8'hC9, 8'hE2);
    mem_wr(16'hEE02, 1'b1, 0);
    mem_wr(16'hEE03, 1'b0, 0);
    sfr_wr(8'hC9, 8'h00);
    mem_wr(16'hEE04, 1'b0, 0);
    chk(soft_seen, 1'b0);
    sfr_wr(8'h97, 8'h65);
    sfr_wr(8'h97, 8'h56);
    chk(soft_seen, 1'b1);
    sfr_rd(8'h97, 8'h00);
    $display("test writes done");
    i_flash.mem[14'h3FFF] = 8'h00;
    do_reset();
    chk(o_cfg_high, 8'h00);
    foreach (T2[i]) mem_rd(T2[i]);
    $display("test unlocked done");
    tally_and_finish();
  end
endmodule
